// File: rtl/pto_pkg.sv
package pto_pkg;
    localparam int UNITS = 12;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int NS_W = 30;
    localparam int SEC_W = 32;
    localparam int WIDTH_W = 24;
    // register offsets
    localparam logic [11:0] ADDR_ENABLE = 12'h206;
    localparam logic [11:0] ADDR_SOFT_RST = 12'h208;
    localparam logic [11:0] ADDR_WIDTH_SKEW = 12'h20a;
    localparam logic [11:0] ADDR_T1_NS_LO = 12'h220;
    localparam logic [11:0] ADDR_T1_NS_HI = 12'h222;
    localparam logic [11:0] ADDR_T1_SEC_LO = 12'h224;
    localparam logic [11:0] ADDR_T1_SEC_HI = 12'h226;
    // reset values
    localparam logic [11:0] RST_UNITS = 12'h000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [11:0] RST_WIDTH_SKEW = 12'h000;
    // field positions
    localparam int SKEW_SEL_BIT = 11;
    localparam int SKEW_LSB = 8;
    localparam int SKEW_MSB = 10;
    localparam int WEXT_MSB = 7;
    localparam int NS_HI_MSB = 13;
    // skew step in ns per code: fine range 0..7, coarse range 0..28
    localparam logic [4:0] SKEW_FINE_STEP_NS = 5'h01;
    localparam logic [4:0] SKEW_COARSE_STEP_NS = 5'h04;
    // shortest unit 12 pulse, in clock cycles
    localparam logic [23:0] PULSE_MIN_CYCLES = 24'h000001;
endpackage : pto_pkg

// File: rtl/pto_trigger_ctrl.sv
// Behaviour
// - twelve enable bits, self-clear on trigger
// - self-clearing per-unit soft reset to defaults
// - unit 1 skew: 0-7 or 0-28 ns
// - unit 12 width bits 23:16 extension
// - unit 1 nanosecond target low word
// - unit 1 nanosecond high fourteen bits
// - unit 1 seconds target low word
// - unit 1 seconds target high word
// - armed unit waits for target time
// - late target with notify sets error
`timescale 1ns/1ps
module pto_trigger_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic [pto_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pto_pkg::DATA_W-1:0] reg_wdata,
    output logic [pto_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pto_pkg::SEC_W-1:0] sys_sec,
    input wire logic [pto_pkg::NS_W-1:0] sys_nsec,
    input wire logic [pto_pkg::UNITS-1:0] cfg_trigger_now,
    input wire logic [pto_pkg::UNITS-1:0] cfg_notify,
    input wire logic [pto_pkg::UNITS-2:0] ext_reached,
    input wire logic [pto_pkg::UNITS-2:0] ext_late,
    input wire logic [pto_pkg::DATA_W-1:0] unit12_width_low,
    output logic [pto_pkg::UNITS-1:0] trig_event,
    output logic [pto_pkg::UNITS-1:0] trigger_unit_error_flags,
    output logic [pto_pkg::UNITS-1:0] trig_active,
    output logic [4:0] unit1_skew_ns,
    output logic unit12_pulse
);
    import pto_pkg::*;

    // returns {later, equal} of system time against target
    function automatic logic [1:0] time_cmp(input logic [SEC_W-1:0] s,
                                            input logic [NS_W-1:0] ns,
                                            input logic [SEC_W-1:0] ts,
                                            input logic [NS_W-1:0] tns);
        logic gt;
        logic eq;
        gt = (s > ts) || ((s == ts) && (ns > tns));
        eq = (s == ts) && (ns == tns);
        return {gt, eq};
    endfunction : time_cmp

    logic [UNITS-1:0] en_q, en_d, en_prev_q, en_prev_d;
    logic [UNITS-1:0] srst_q, srst_d;
    logic [UNITS-1:0] err_q, err_d;
    logic [UNITS-1:0] event_q, event_d;
    logic [UNITS-1:0] active_q, active_d;
    logic [11:0] wskew_q, wskew_d;
    logic [NS_W-1:0] t1_ns_q, t1_ns_d;
    logic [SEC_W-1:0] t1_sec_q, t1_sec_d;
    logic [WIDTH_W-1:0] cnt_q, cnt_d;
    logic pulse_q, pulse_d;
    logic [4:0] skew_q, skew_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] cmp1;
    logic [UNITS-1:0] reached, late, arm_new, err_set, fire;
    logic [WIDTH_W-1:0] width24;
    logic wr_en, wr_srst, wr_ws;

    // write strobe for one register offset
    function automatic logic wr_hit(input logic wr,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] offset);
        return wr && (a == offset);
    endfunction : wr_hit

    // path delay in ns: 1 ns or 4 ns per code step
    function automatic logic [4:0] skew_ns(input logic fine,
                                           input logic [2:0] code);
        logic [4:0] step;
        step = fine ? SKEW_FINE_STEP_NS : SKEW_COARSE_STEP_NS;
        return 5'(code * step);
    endfunction : skew_ns

    // time compare and strobe decode
    always_comb begin
        cmp1 = time_cmp(sys_sec, sys_nsec, t1_sec_q, t1_ns_q);
        reached = {ext_reached, cmp1[1] | cmp1[0]};
        late = {ext_late, cmp1[1]};
        wr_en = wr_hit(reg_wr, reg_addr, ADDR_ENABLE);
        wr_srst = wr_hit(reg_wr, reg_addr, ADDR_SOFT_RST);
        wr_ws = wr_hit(reg_wr, reg_addr, ADDR_WIDTH_SKEW);
        width24 = {wskew_q[WEXT_MSB:0], unit12_width_low};
        arm_new = en_q & ~en_prev_q;
        // lateness is judged when the unit is first armed
        err_set = arm_new & late & cfg_notify & ~cfg_trigger_now & ~err_q;
        fire = en_q & ~err_q & ~err_set & reached;
    end

    // per-unit enable, soft reset, error and event
    always_comb begin
        // software write wins over the hardware self-clear
        en_d = wr_en ? reg_wdata[UNITS-1:0] : (en_q & ~fire);
        en_d = en_d & ~srst_q;
        en_prev_d = en_q & ~srst_q;
        srst_d = wr_srst ? reg_wdata[UNITS-1:0] : RST_UNITS;
        err_d = (err_q | err_set) & en_d;
        event_d = fire & ~srst_q;
        active_d = en_d & ~err_d;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_q <= RST_UNITS;
            en_prev_q <= RST_UNITS;
            srst_q <= RST_UNITS;
            err_q <= RST_UNITS;
            event_q <= RST_UNITS;
            active_q <= RST_UNITS;
        end else begin
            en_q <= en_d;
            en_prev_q <= en_prev_d;
            srst_q <= srst_d;
            err_q <= err_d;
            event_q <= event_d;
            active_q <= active_d;
        end
    end

    // unit 1 path delay and unit 12 width extension
    always_comb begin
        wskew_d = wr_ws ? reg_wdata[11:0] : wskew_q;
        skew_d = skew_ns(wskew_d[SKEW_SEL_BIT], wskew_d[SKEW_MSB:SKEW_LSB]);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wskew_q <= RST_WIDTH_SKEW;
            skew_q <= 5'h00;
        end else begin
            wskew_q <= wskew_d;
            skew_q <= skew_d;
        end
    end

    // unit 1 target time
    always_comb begin
        t1_ns_d = t1_ns_q;
        t1_sec_d = t1_sec_q;
        if (wr_hit(reg_wr, reg_addr, ADDR_T1_NS_LO)) begin
            t1_ns_d[15:0] = reg_wdata;
        end
        if (wr_hit(reg_wr, reg_addr, ADDR_T1_NS_HI)) begin
            t1_ns_d[NS_W-1:16] = reg_wdata[NS_HI_MSB:0];
        end
        if (wr_hit(reg_wr, reg_addr, ADDR_T1_SEC_LO)) begin
            t1_sec_d[15:0] = reg_wdata;
        end
        if (wr_hit(reg_wr, reg_addr, ADDR_T1_SEC_HI)) begin
            t1_sec_d[SEC_W-1:16] = reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            t1_ns_q <= '0;
            t1_sec_q <= '0;
        end else begin
            t1_ns_q <= t1_ns_d;
            t1_sec_q <= t1_sec_d;
        end
    end

    // unit 12 output held for the 24-bit width in cycles
    always_comb begin
        if (srst_q[UNITS-1]) begin
            cnt_d = '0;
        end else if (fire[UNITS-1]) begin
            cnt_d = (width24 == '0) ? PULSE_MIN_CYCLES : width24;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - PULSE_MIN_CYCLES;
        end else begin
            cnt_d = cnt_q;
        end
        pulse_d = (cnt_d != '0);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    // registered read data, held until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_ENABLE: rdata_d = {4'h0, en_q};
                ADDR_SOFT_RST: rdata_d = {4'h0, srst_q};
                ADDR_WIDTH_SKEW: rdata_d = {4'h0, wskew_q};
                ADDR_T1_NS_LO: rdata_d = t1_ns_q[15:0];
                ADDR_T1_NS_HI: rdata_d = {2'h0, t1_ns_q[NS_W-1:16]};
                ADDR_T1_SEC_LO: rdata_d = t1_sec_q[15:0];
                ADDR_T1_SEC_HI: rdata_d = t1_sec_q[SEC_W-1:16];
                default: rdata_d = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= RST_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign trig_event = event_q;
    assign trigger_unit_error_flags = err_q;
    assign trig_active = active_q;
    assign unit1_skew_ns = skew_q;
    assign unit12_pulse = pulse_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_fire_clears_en: assert property (
        (fire[0] && !wr_en && !srst_q[0]) |=> !en_q[0] && event_q[0])
        else $error("unit 1 enable not cleared after trigger");
    a_event_armed: assert property (
        event_q[0] |-> $past(en_q[0]))
        else $error("unit 1 fired while not enabled");
    a_srst_pulse: assert property (
        (wr_srst && reg_wdata[0]) |=> srst_q[0] ##1 (!srst_q[0] || $past(wr_srst)))
        else $error("soft reset bit did not self-clear");
    a_srst_kills: assert property (
        srst_q[0] |=> !en_q[0] && !err_q[0] && !event_q[0] && !active_q[0])
        else $error("soft reset left unit 1 active");
    a_skew_value: assert property (
        wr_ws |=> unit1_skew_ns == ($past(reg_wdata[SKEW_SEL_BIT])
            ? {2'h0, $past(reg_wdata[SKEW_MSB:SKEW_LSB])}
            : {$past(reg_wdata[SKEW_MSB:SKEW_LSB]), 2'h0}))
        else $error("unit 1 skew compensation wrong");
    a_pulse_width: assert property (
        (fire[UNITS-1] && !srst_q[UNITS-1] && width24 > 24'h000002)
        |=> unit12_pulse [*2] ##0 (cnt_q == $past(width24, 2) - 24'h000001))
        else $error("unit 12 pulse width wrong");
    a_ns_low_write: assert property (
        (reg_wr && reg_addr == ADDR_T1_NS_LO) |=> t1_ns_q[15:0] == $past(reg_wdata))
        else $error("ns low word not stored");
    a_ns_high_zero: assert property (
        (reg_rd && reg_addr == ADDR_T1_NS_HI) |=> reg_rdata[15:14] == 2'h0
            && reg_rdata[NS_HI_MSB:0] == $past(t1_ns_q[NS_W-1:16]))
        else $error("ns high word readback wrong");
    a_sec_low_write: assert property (
        (reg_wr && reg_addr == ADDR_T1_SEC_LO) |=> t1_sec_q[15:0] == $past(reg_wdata))
        else $error("seconds low word not stored");
    a_sec_high_write: assert property (
        (reg_wr && reg_addr == ADDR_T1_SEC_HI) |=> t1_sec_q[31:16] == $past(reg_wdata))
        else $error("seconds high word not stored");
    a_wait_target: assert property (
        event_q[0] |-> $past(reached[0]))
        else $error("unit 1 fired before target time");
    a_late_error: assert property (
        (arm_new[0] && late[0] && cfg_notify[0] && !cfg_trigger_now[0] && !srst_q[0]
         && !wr_en) |=> err_q[0] && !event_q[0] ##1 err_q[0] || !en_q[0])
        else $error("late target did not flag error");
    a_compare_fire: assert property (
        (en_q[0] && !err_q[0] && !err_set[0] && reached[0] && !srst_q[0]) |=> event_q[0])
        else $error("unit 1 missed reached target");
    a_en_write: assert property (
        (wr_en && !srst_q[0]) |=> en_q[0] == $past(reg_wdata[0]))
        else $error("unit 1 enable write not stored");
    a_rd_enable: assert property (
        (reg_rd && reg_addr == ADDR_ENABLE) |=> reg_rdata == {4'h0, $past(en_q)})
        else $error("enable readback wrong");
    a_err_clear: assert property (
        (wr_en && !reg_wdata[0]) |=> !err_q[0] && !en_q[0])
        else $error("unit 1 error not cleared with enable");
    a_err_blocks: assert property (
        err_q[0] |=> !event_q[0])
        else $error("unit 1 fired while in error");
    a_unit12_srst: assert property (
        (wr_srst && reg_wdata[UNITS-1]) |=> srst_q[UNITS-1] ##1 !unit12_pulse && !en_q[UNITS-1])
        else $error("soft reset left unit 12 running");
    a_pulse_ends: assert property (
        (unit12_pulse && cnt_q == 24'h000001 && !fire[UNITS-1]) |=> !unit12_pulse)
        else $error("unit 12 pulse overran its width");
    a_width_ext: assert property (
        wr_ws |=> width24[23:16] == $past(reg_wdata[WEXT_MSB:0]))
        else $error("unit 12 width extension not stored");
    a_ns_high_write: assert property (
        (reg_wr && reg_addr == ADDR_T1_NS_HI) |=> t1_ns_q[NS_W-1:16] == $past(reg_wdata[NS_HI_MSB:0]))
        else $error("ns high word not stored");
    a_sec_high_read: assert property (
        (reg_rd && reg_addr == ADDR_T1_SEC_HI) |=> reg_rdata == $past(t1_sec_q[SEC_W-1:16]))
        else $error("seconds high word readback wrong");

    c_unit1_fire: cover property (en_q[0] ##[1:20] event_q[0]);
    c_late_error: cover property ($rose(err_q[0]));
    c_unit12_pulse: cover property ($rose(unit12_pulse) ##[2:20] $fell(unit12_pulse));
    c_soft_reset: cover property (en_q[3] ##1 srst_q[3]);
    c_trigger_now: cover property (fire[0] && cfg_trigger_now[0] && late[0]);
endmodule : pto_trigger_ctrl

// File: verification/pto_time_src.sv
`timescale 1ns/1ps
module pto_time_src (
    input wire logic clock,
    input wire logic rst,
    input wire logic [pto_pkg::UNITS-1:0] trig_event,
    output logic [pto_pkg::SEC_W-1:0] sys_sec,
    output logic [pto_pkg::NS_W-1:0] sys_nsec,
    output logic [31:0] evcount
);
    import pto_pkg::*;
    // time base at 10 ns a cycle, pin event counter for unit 1
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_sec <= 32'h00000001;
            sys_nsec <= '0;
            evcount <= '0;
        end else begin
            sys_nsec <= (sys_nsec >= 30'h3b9ac9f6) ? '0 : sys_nsec + 30'h00a;
            sys_sec <= sys_sec + {31'h0, sys_nsec >= 30'h3b9ac9f6};
            evcount <= evcount + {31'h0, trig_event[0]};
        end
    end
endmodule : pto_time_src

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
    import pto_pkg::*;
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, unit12_pulse;
    logic [11:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, unit12_width_low = 0, rv;
    logic [SEC_W-1:0] sys_sec;
    logic [NS_W-1:0] sys_nsec, tgt;
    logic [UNITS-1:0] cfg_trigger_now = 0, cfg_notify = 0, trig_event, err, trig_active;
    logic [UNITS-2:0] ext_reached = 0, ext_late = 0;
    logic [4:0] unit1_skew_ns;
    logic [31:0] evcount;
    int mismatches = 0, checks = 0, n;
    always #5 clock = ~clock;
    pto_trigger_ctrl pto_trigger_ctrl_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sys_sec(sys_sec), .sys_nsec(sys_nsec), .cfg_trigger_now(cfg_trigger_now),
        .cfg_notify(cfg_notify), .ext_reached(ext_reached), .ext_late(ext_late),
        .unit12_width_low(unit12_width_low), .trig_event(trig_event),
        .trigger_unit_error_flags(err), .trig_active(trig_active),
        .unit1_skew_ns(unit1_skew_ns), .unit12_pulse(unit12_pulse));
    pto_time_src pto_time_src_inst (.clock(clock), .rst(rst), .trig_event(trig_event),
        .sys_sec(sys_sec), .sys_nsec(sys_nsec), .evcount(evcount));
    task chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(logic [11:0] a, logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clock);
        reg_wr <= 0;
    endtask : wr
    task rd(logic [11:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clock);
        reg_rd <= 0;
        @(negedge clock);
        d = reg_rdata;
    endtask : rd
    task t_regs;
        logic [11:0] a[7] = '{ADDR_ENABLE, ADDR_SOFT_RST, ADDR_T1_NS_LO, ADDR_T1_NS_HI,
            ADDR_T1_SEC_LO, ADDR_T1_SEC_HI, 12'h20c};
        logic [15:0] w[7] = '{16'hf000, 16'h0, 16'ha5c3, 16'hffff, 16'h1234, 16'hfedc, 16'hffff};
        logic [15:0] e[7] = '{16'h0, 16'h0, 16'ha5c3, 16'h3fff, 16'h1234, 16'hfedc, 16'h0};
        chk(trig_event, 0);
        chk(err, 0);
        chk(trig_active, 0);
        for (int i = 0; i < 7; i++) begin
            rd(a[i], rv);
            chk(rv, 0);
            wr(a[i], w[i]);
            rd(a[i], rv);
            chk(rv, e[i]);
        end
    endtask : t_regs
    task t_fire;
        tgt = sys_nsec + 30'h258;
        wr(ADDR_T1_NS_LO, tgt[15:0]);
        wr(ADDR_T1_NS_HI, {2'h0, tgt[29:16]});
        wr(ADDR_T1_SEC_LO, sys_sec[15:0]);
        wr(ADDR_T1_SEC_HI, sys_sec[31:16]);
        wr(ADDR_ENABLE, 16'h0001);
        n = 0;
        while (trig_event[0] !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk(n > 20 && n < 200, 1);
        chk(sys_nsec >= tgt && sys_nsec <= tgt + 30, 1);
        rd(ADDR_ENABLE, rv);
        chk(rv, 0);
        chk(evcount, 1);
    endtask : t_fire
    task t_late;
        @(posedge clock);
        cfg_notify <= 12'h003;
        ext_late[0] <= 1;
        wr(ADDR_ENABLE, 16'h0003);
        repeat (2) @(negedge clock);
        chk({err[1:0], trig_event[1:0]}, 4'b1100);
        wr(ADDR_ENABLE, 16'h0000);
        repeat (2) @(negedge clock);
        chk(err[1:0], 0);
        @(posedge clock);
        ext_late[0] <= 0;
        cfg_trigger_now[0] <= 1;
        wr(ADDR_ENABLE, 16'h0001);
        repeat (2) @(negedge clock);
        chk({err[0], trig_event[0]}, 2'b01);
        @(posedge clock);
        cfg_notify <= 0;
        cfg_trigger_now[0] <= 0;
        @(negedge clock);
        chk(evcount, 2);
    endtask : t_late
    task t_srst;
        wr(ADDR_ENABLE, 16'h0004);
        @(negedge clock);
        chk(trig_active[2], 1);
        wr(ADDR_SOFT_RST, 16'h0004);
        repeat (2) @(negedge clock);
        chk(trig_active[2], 0);
        rd(ADDR_ENABLE, rv);
        chk(rv, 0);
        rd(ADDR_SOFT_RST, rv);
        chk(rv, 0);
    endtask : t_srst
    task t_skew;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 8; c++) begin
                wr(ADDR_WIDTH_SKEW, 16'(s * 2048 + c * 256));
                @(negedge clock);
                chk(unit1_skew_ns, s ? c : c * 4);
            end
        end
    endtask : t_skew
    task t_pulse;
        wr(ADDR_WIDTH_SKEW, 16'hf001);
        unit12_width_low <= 16'h0005;
        ext_reached[10] <= 1;
        wr(ADDR_ENABLE, 16'h0800);
        n = 0;
        repeat (66000) begin
            @(negedge clock);
            n += unit12_pulse;
        end
        chk(n, 32'h10005);
        @(posedge clock);
        ext_reached[10] <= 0;
        rd(ADDR_WIDTH_SKEW, rv);
        chk(rv, 16'h0001);
    endtask : t_pulse
    task conclude;
        $display("counts: mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial begin
        #900000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 0;
        t_regs();
        t_fire();
        t_late();
        t_srst();
        t_skew();
        t_pulse();
        conclude();
    end
endmodule : tb
